// ### common/bstap_cfg.svh
// constants for the boundary-scan test access port
`ifndef BSTAP_CFG_SVH
`define BSTAP_CFG_SVH
`define BSTAP_IR_W        4
`define BSTAP_IR_CAPTURE  4'h1
`define BSTAP_OP_EXTEST   4'h0
`define BSTAP_OP_SAMPLE   4'h1
`define BSTAP_OP_IDENT    4'h2
`define BSTAP_OP_HIGHZ    4'h4
`define BSTAP_OP_BYPASS   4'hf
`define BSTAP_ID_W        32
`define BSTAP_ID_VER_HI   31
`define BSTAP_ID_VER_LO   28
`define BSTAP_ID_PART_HI  27
`define BSTAP_ID_PART_LO  12
`define BSTAP_ID_MFR_HI   11
`define BSTAP_ID_MFR_LO   1
`define BSTAP_RESET_TMS_N 5
`endif

// ### common/bstap_pkg.sv
// types for the boundary-scan test access port
package bstap_pkg;
	typedef enum logic [3:0] {
		BSTAP_RESET   = 4'h0,
		BSTAP_IDLE    = 4'h1,
		BSTAP_SEL_DR  = 4'h3,
		BSTAP_CAP_DR  = 4'h2,
		BSTAP_SH_DR   = 4'h6,
		BSTAP_EX1_DR  = 4'h7,
		BSTAP_PA_DR   = 4'h5,
		BSTAP_EX2_DR  = 4'h4,
		BSTAP_UPD_DR  = 4'hc,
		BSTAP_SEL_IR  = 4'hd,
		BSTAP_CAP_IR  = 4'hf,
		BSTAP_SH_IR   = 4'he,
		BSTAP_EX1_IR  = 4'ha,
		BSTAP_PA_IR   = 4'hb,
		BSTAP_EX2_IR  = 4'h9,
		BSTAP_UPD_IR  = 4'h8
	} bstap_state_t;

	typedef struct packed {
		logic sel_bsr;
		logic sel_id;
		logic sel_byp;
		logic highz;
		logic extest;
	} bstap_dec_t;
endpackage

// ### logic/bstap_top.sv
// boundary-scan tap controller with instruction, bypass and identification registers
`timescale 1ns/1ps
`include "bstap_cfg.svh"

// Function
// - five tms-high clocks force test-logic-reset
// - no power-up reset; trst or tms
// - states change on rising tck by tms
// - tap overrides queue function
// - test-logic-reset disables all test logic
// - run-test-idle acts only per instruction
// - select states branch on tms
// - capture-ir loads pattern ending 01
// - shift-ir moves ir between tdi, tdo
// - exit1-ir to pause or update; pause holds
// - update-ir latches instruction on falling tck
// - four-bit ir, lsb nearest tdo
// - capture-dr loads selected data register
// - dr states mirror ir states
// - data registers parallel, instruction selects
// - bypass single stage, captures zero
// - bypass shifting leaves function unaffected
// - read-only 32-bit identification register
// - id: version, part, maker, bit0 one
// - four test inputs, one serial output
// - decode 00,01,02,04,0f instruction codes
// - high-z disables outputs, selects bypass
module bstap_top #(
	parameter logic [3:0]  ID_VERSION = 4'h0,  // arbitrary value
	parameter logic [15:0] ID_PART    = 16'h0001, // arbitrary value
	parameter logic [10:0] ID_MAKER   = 11'h001  // arbitrary value
) (
	input  wire logic i_mclk,         // system clock
	input  wire logic i_rst_n,        // system reset, sync, active low
	input  wire logic i_tck,          // test clock, link domain
	input  wire logic i_tms,          // test mode select
	input  wire logic i_tdi,          // test data in
	input  wire logic i_trst_n,       // test reset, async, active low
	input  wire logic i_bsr_so,       // serial out of boundary chain
	output logic      o_tdo,          // test data out
	output logic      o_tdo_oe,       // tdo output enable
	output logic      o_bsr_capture,  // boundary chain capture, tck domain
	output logic      o_bsr_shift,    // boundary chain shift, tck domain
	output logic      o_bsr_update,   // boundary chain update, tck domain
	output logic      o_extest,       // boundary chain drives pins, mclk domain
	output logic      o_outputs_off,  // functional outputs disabled, mclk domain
	output logic      o_queue_enable  // queue function allowed, mclk domain
);
	bstap_pkg::bstap_state_t state;
	bstap_pkg::bstap_state_t next_state;
	logic [`BSTAP_IR_W-1:0]  ir_shift;
	logic [`BSTAP_IR_W-1:0]  ir_cur;
	logic [`BSTAP_ID_W-1:0]  id_shift;
	logic                    byp;
	logic                    tap_was_reset;
	bstap_pkg::bstap_dec_t   dec;
	wire                     dec_bsr;
	wire                     dec_id;
	wire                     dec_byp;
	wire                     dec_highz;
	wire                     dec_extest;
	wire  [`BSTAP_ID_W-1:0]  id_word;
	wire                     dr_so;
	wire                     st_cap_dr;
	wire                     st_sh_dr;
	wire                     st_cap_ir;
	wire                     st_sh_ir;

	// tms path: state change on every rising tck, trst async
	always_comb
	begin
		next_state = state;
		case (state)
			bstap_pkg::BSTAP_RESET:  next_state = i_tms ? bstap_pkg::BSTAP_RESET  : bstap_pkg::BSTAP_IDLE;
			bstap_pkg::BSTAP_IDLE:   next_state = i_tms ? bstap_pkg::BSTAP_SEL_DR : bstap_pkg::BSTAP_IDLE;
			bstap_pkg::BSTAP_SEL_DR: next_state = i_tms ? bstap_pkg::BSTAP_SEL_IR : bstap_pkg::BSTAP_CAP_DR;
			bstap_pkg::BSTAP_CAP_DR: next_state = i_tms ? bstap_pkg::BSTAP_EX1_DR : bstap_pkg::BSTAP_SH_DR;
			bstap_pkg::BSTAP_SH_DR:  next_state = i_tms ? bstap_pkg::BSTAP_EX1_DR : bstap_pkg::BSTAP_SH_DR;
			bstap_pkg::BSTAP_EX1_DR: next_state = i_tms ? bstap_pkg::BSTAP_UPD_DR : bstap_pkg::BSTAP_PA_DR;
			bstap_pkg::BSTAP_PA_DR:  next_state = i_tms ? bstap_pkg::BSTAP_EX2_DR : bstap_pkg::BSTAP_PA_DR;
			bstap_pkg::BSTAP_EX2_DR: next_state = i_tms ? bstap_pkg::BSTAP_UPD_DR : bstap_pkg::BSTAP_SH_DR;
			bstap_pkg::BSTAP_UPD_DR: next_state = i_tms ? bstap_pkg::BSTAP_SEL_DR : bstap_pkg::BSTAP_IDLE;
			bstap_pkg::BSTAP_SEL_IR: next_state = i_tms ? bstap_pkg::BSTAP_RESET  : bstap_pkg::BSTAP_CAP_IR;
			bstap_pkg::BSTAP_CAP_IR: next_state = i_tms ? bstap_pkg::BSTAP_EX1_IR : bstap_pkg::BSTAP_SH_IR;
			bstap_pkg::BSTAP_SH_IR:  next_state = i_tms ? bstap_pkg::BSTAP_EX1_IR : bstap_pkg::BSTAP_SH_IR;
			bstap_pkg::BSTAP_EX1_IR: next_state = i_tms ? bstap_pkg::BSTAP_UPD_IR : bstap_pkg::BSTAP_PA_IR;
			bstap_pkg::BSTAP_PA_IR:  next_state = i_tms ? bstap_pkg::BSTAP_EX2_IR : bstap_pkg::BSTAP_PA_IR;
			bstap_pkg::BSTAP_EX2_IR: next_state = i_tms ? bstap_pkg::BSTAP_UPD_IR : bstap_pkg::BSTAP_SH_IR;
			bstap_pkg::BSTAP_UPD_IR: next_state = i_tms ? bstap_pkg::BSTAP_SEL_DR : bstap_pkg::BSTAP_IDLE;
			default:                 next_state = bstap_pkg::BSTAP_RESET;
		endcase
	end

	// no mclk reset here: the tap is reset only by trst or tms
	always_ff @(posedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
			state <= bstap_pkg::BSTAP_RESET;
		else
			state <= next_state;
	end

	assign st_cap_dr = (state == bstap_pkg::BSTAP_CAP_DR);
	assign st_sh_dr  = (state == bstap_pkg::BSTAP_SH_DR);
	assign st_cap_ir = (state == bstap_pkg::BSTAP_CAP_IR);
	assign st_sh_ir  = (state == bstap_pkg::BSTAP_SH_IR);

	// instruction shift stages; other states (pause, exit) hold contents
	always_ff @(posedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
			ir_shift <= `BSTAP_IR_CAPTURE;
		else if (st_cap_ir)
			ir_shift <= `BSTAP_IR_CAPTURE;
		else if (st_sh_ir)
			ir_shift <= {i_tdi, ir_shift[`BSTAP_IR_W-1:1]};
	end

	// hold latch loads on falling tck; reset picks identification
	always_ff @(negedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
			ir_cur <= `BSTAP_OP_IDENT;
		else if (state == bstap_pkg::BSTAP_RESET)
			ir_cur <= `BSTAP_OP_IDENT;
		else if (state == bstap_pkg::BSTAP_UPD_IR)
			ir_cur <= ir_shift;
	end

	assign dec_bsr    = (ir_cur == `BSTAP_OP_EXTEST) || (ir_cur == `BSTAP_OP_SAMPLE);
	assign dec_id     = (ir_cur == `BSTAP_OP_IDENT);
	assign dec_highz  = (ir_cur == `BSTAP_OP_HIGHZ);
	assign dec_extest = (ir_cur == `BSTAP_OP_EXTEST);
	assign dec_byp    = !dec_bsr && !dec_id;
	// one driver for the whole decode word, members in declaration order
	assign dec = {dec_bsr, dec_id, dec_byp, dec_highz, dec_extest};

	assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};

	// data registers in parallel between tdi and the common output
	always_ff @(posedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
			byp <= 1'b0;
		else if (st_cap_dr && dec.sel_byp)
			byp <= 1'b0;
		else if (st_sh_dr && dec.sel_byp)
			byp <= i_tdi;
	end

	always_ff @(posedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
			id_shift <= '0;
		else if (st_cap_dr && dec.sel_id)
			id_shift <= id_word;
		else if (st_sh_dr && dec.sel_id)
			id_shift <= {i_tdi, id_shift[`BSTAP_ID_W-1:1]};
	end

	assign dr_so = dec.sel_bsr ? i_bsr_so : (dec.sel_id ? id_shift[0] : byp);

	// tdo changes on falling tck, enabled only in shift states
	always_ff @(negedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
		begin
			o_tdo    <= 1'b0;
			o_tdo_oe <= 1'b0;
		end
		else
		begin
			o_tdo    <= st_sh_ir ? ir_shift[0] : dr_so;
			o_tdo_oe <= st_sh_ir || st_sh_dr;
		end
	end

	// boundary chain controls registered on falling tck
	always_ff @(negedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
		begin
			o_bsr_capture <= 1'b0;
			o_bsr_shift   <= 1'b0;
			o_bsr_update  <= 1'b0;
		end
		else
		begin
			o_bsr_capture <= st_cap_dr && dec.sel_bsr;
			o_bsr_shift   <= st_sh_dr && dec.sel_bsr;
			o_bsr_update  <= (state == bstap_pkg::BSTAP_UPD_DR) && dec.sel_bsr;
		end
	end

	// remembers that the tap has seen a reset since power-up
	always_ff @(posedge i_tck or negedge i_trst_n)
	begin
		if (!i_trst_n)
			tap_was_reset <= 1'b1;
		else if (state == bstap_pkg::BSTAP_RESET)
			tap_was_reset <= 1'b1;
	end

	// level crossings into mclk: three flops, change taken when 2nd and 3rd agree
	logic [2:0] sync_ext;
	logic [2:0] sync_hz;
	logic [2:0] sync_rst;

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			sync_ext <= 3'h0;
			sync_hz  <= 3'h0;
			sync_rst <= 3'h0;
		end
		else
		begin
			sync_ext <= {sync_ext[1:0], dec.extest};
			sync_hz  <= {sync_hz[1:0], dec.highz};
			sync_rst <= {sync_rst[1:0], tap_was_reset};
		end
	end

	always_ff @(posedge i_mclk)
	begin
		if (!i_rst_n)
		begin
			o_extest       <= 1'b0;
			o_outputs_off  <= 1'b0;
			o_queue_enable <= 1'b0;
		end
		else
		begin
			if (sync_ext[2] == sync_ext[1])
				o_extest <= sync_ext[2];
			if (sync_hz[2] == sync_hz[1])
				o_outputs_off <= sync_hz[2];
			if (sync_rst[2] == sync_rst[1])
				o_queue_enable <= sync_rst[2];
		end
	end
endmodule

// ### testbench/bstap_top_props.sv
// assertion checker for the tap port
`timescale 1ns/1ps
module bstap_top_props (
	input wire logic i_mclk,         // system clock
	input wire logic i_rst_n,        // system reset
	input wire logic i_tck,          // test clock
	input wire logic i_tms,          // mode select
	input wire logic i_trst_n,       // tap reset
	input wire logic o_tdo,          // serial out
	input wire logic o_tdo_oe,       // serial out enable
	input wire logic o_bsr_shift,    // chain shift
	input wire logic o_bsr_capture,  // chain capture
	input wire logic o_bsr_update,   // chain update
	input wire logic o_queue_enable  // queue allowed
);
	logic [2:0] n_hi;
	// run of tms-high edges; trst counts as a full run
	always_ff @(posedge i_tck or negedge i_trst_n)
		if (!i_trst_n)
			n_hi <= 3'h5;
		else
			n_hi <= !i_tms ? 3'h0 : (n_hi == 3'h5) ? 3'h5 : n_hi + 3'h1;
	sequence s_idle;
		n_hi == 3'h5 && !i_tms;
	endsequence
	sequence s_to_shir;
		s_idle ##1 i_tms [*2] ##1 !i_tms [*2];
	endsequence
	sequence s_to_shdr;
		s_idle ##1 i_tms ##1 !i_tms [*2];
	endsequence
	a_tms_reset: assert property (@(posedge i_tck) disable iff (!i_trst_n) i_tms [*5] |=> !o_tdo_oe)
		else $error("tdo enabled after tms reset");
	a_tdo_idle: assert property (@(posedge i_tck) disable iff (!i_trst_n) n_hi == 3'h5 |-> !o_tdo_oe && !o_bsr_shift)
		else $error("test logic active in reset");
	a_bsr_quiet: assert property (@(posedge i_tck) disable iff (!i_trst_n) n_hi == 3'h5 |-> !o_bsr_capture && !o_bsr_update)
		else $error("boundary chain active in reset");
	a_ir_capture: assert property (@(posedge i_tck) disable iff (!i_trst_n) s_to_shir |=> o_tdo_oe && o_tdo)
		else $error("ir capture bit0 wrong");
	a_ir_bit_order: assert property (@(posedge i_tck) disable iff (!i_trst_n) s_to_shir ##1 !i_tms |=> !o_tdo)
		else $error("ir capture bit1 wrong");
	a_id_first: assert property (@(posedge i_tck) disable iff (!i_trst_n) s_to_shdr |=> o_tdo && !o_bsr_shift)
		else $error("id bit0 wrong");
	a_rst_clears: assert property (@(posedge i_mclk) !i_rst_n |=> !o_queue_enable)
		else $error("queue enabled in reset");
	a_qen_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_n) o_queue_enable |=> o_queue_enable)
		else $error("queue enable dropped");
	a_qen_sets: assert property (@(posedge i_mclk) disable iff (!i_rst_n) $fell(i_trst_n) |-> ##[1:8] o_queue_enable)
		else $error("queue enable late");
endmodule
bind bstap_top bstap_top_props u_props (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tck(i_tck), .i_tms(i_tms),
	.i_trst_n(i_trst_n), .o_tdo(o_tdo), .o_tdo_oe(o_tdo_oe), .o_bsr_shift(o_bsr_shift),
	.o_bsr_capture(o_bsr_capture), .o_bsr_update(o_bsr_update),
	.o_queue_enable(o_queue_enable));

// ### testbench/bstap_tester.sv
// board test controller model for the tap pins
`timescale 1ns/1ps
module bstap_tester (
	output logic      o_tck,    // test clock, still between frames
	output logic      o_tms,    // mode select
	output logic      o_tdi,    // data in
	output logic      o_trst_n, // tap reset
	input  wire logic i_tdo     // data out
);
	initial
	begin
		o_tck = 1'b0;
		o_tms = 1'b1;
		o_tdi = 1'b0;
		o_trst_n = 1'b1;
	end
	task automatic step(input logic m, input logic d, output logic q);
		o_tms <= m;
		o_tdi <= d;
		#40 q = i_tdo;
		o_tck <= 1'b1;
		#40 o_tck <= 1'b0;
	endtask
	task automatic do_trst;
		o_trst_n <= 1'b0;
		#60 o_trst_n <= 1'b1;
		#20;
	endtask
	task automatic go_reset;
		logic q;
		repeat (5) step(1'b1, 1'b0, q);
	endtask
	// from idle through one scan and back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
		logic q;
		dout = '0;
		step(1'b1, 1'b0, q);
		if (ir)
			step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
		step(1'b0, 1'b0, q);
		for (int i = 0; i < n; i++)
		begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b0, q);
		step(1'b0, 1'b0, q);
	endtask
endmodule

// ### testbench/testbench.sv
// self-checking bench for the tap port
`timescale 1ns/1ps
module testbench;
	localparam logic [3:0]  VER  = 4'h3;     // arbitrary value
	localparam logic [15:0] PART = 16'h1234; // arbitrary value
	localparam logic [10:0] MAKR = 11'h055;  // arbitrary value
	localparam logic [31:0] ID   = {VER, PART, MAKR, 1'b1};
	logic        i_mclk;
	logic        i_rst_n;
	logic        bsr_so;
	logic        q;
	logic [31:0] got;
	int          n_fail;
	int          checks;
	wire logic   tck, tms, tdi, trst_n, tdo, tdo_oe, extest, off, qen;
	always #10 i_mclk = ~i_mclk;
	bstap_top #(.ID_VERSION(VER), .ID_PART(PART), .ID_MAKER(MAKR)) uut (
		.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_trst_n(trst_n),
		.i_bsr_so(bsr_so), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .o_bsr_capture(), .o_bsr_shift(),
		.o_bsr_update(), .o_extest(extest), .o_outputs_off(off), .o_queue_enable(qen));
	bstap_tester tester (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .o_trst_n(trst_n), .i_tdo(tdo));
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("[ERR] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task automatic report_and_stop;
		if (n_fail == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	task automatic t_ident;
		tester.do_trst();
		tester.step(1'b0, 1'b0, q);
		chk(32'(tdo_oe), 32'h0);
		tester.scan(1'b0, 32, 32'h0, got);
		chk(got, ID);
		chk(32'(qen), 32'h1);
	endtask
	task automatic t_codes;
		logic [3:0] codes [7];
		logic [7:0] e;
		codes = '{4'h0, 4'h1, 4'h2, 4'h4, 4'hf, 4'h3, 4'h8};
		foreach (codes[k])
		begin
			tester.go_reset();
			tester.step(1'b0, 1'b0, q);
			tester.scan(1'b1, 4, {28'h0, codes[k]}, got);
			chk(got, 32'h1);
			tester.scan(1'b0, 8, 32'ha5, got);
			e = (codes[k] == 4'h2) ? ID[7:0] : (codes[k] < 4'h2) ? 8'hff : 8'h4a;
			chk(got, {24'h0, e});
			chk({30'h0, extest, off}, {30'h0, codes[k] == 4'h0, codes[k] == 4'h4});
			chk(32'(qen), 32'h1);
		end
	endtask
	task automatic t_selir;
		tester.scan(1'b1, 4, 32'hf, got);
		repeat (3) tester.step(1'b1, 1'b0, q);
		tester.step(1'b0, 1'b0, q);
		tester.scan(1'b0, 32, 32'h0, got);
		chk(got, ID);
	endtask
	initial
	begin
		i_mclk = 1'b0;
		i_rst_n = 1'b0;
		bsr_so = 1'b1;
		n_fail = 0;
		checks = 0;
		repeat (2) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		#3;
		t_ident();
		t_codes();
		t_selir();
		report_and_stop();
	end
	initial
	begin
		#100000;
		n_fail++;
		report_and_stop();
	end
endmodule
